//--- sdci_core.v
`timescale 1ns/1ns
`include "sdci_regs.vh"

module sdci_core #(
    parameter BANK_W = 2,
    parameter ROW_W = 11,
    parameter COL_W = 8,
    parameter DATA_W = 32,
    parameter LANES = 4
)(
    // Clock and reset
    input wire sys_clk_in,
    input wire srst_in,
    // Command pins
    input wire cs_n_in,
    input wire ras_n_in,
    input wire cas_n_in,
    input wire we_n_in,
    input wire cke_in,
    // Address pins
    input wire [BANK_W-1:0] ba_in,
    input wire [`SDCI_OPC_W-1:0] addr_in,
    // Data pins
    input wire [LANES-1:0] dqm_in,
    input wire [DATA_W-1:0] dq_in,
    output reg [DATA_W-1:0] dq_out,
    output reg [LANES-1:0] dq_oe_out,
    // Status
    output reg [(1<<BANK_W)-1:0] bank_open_out,
    output reg self_refresh_out,
    output reg [ROW_W-1:0] refresh_row_out
);

localparam NB = 1 << BANK_W;
localparam AW = BANK_W + ROW_W + COL_W;
localparam LW = COL_W + 1;
localparam BW = DATA_W / LANES;

// ----------------------------------------------------------------
// Functions
// ----------------------------------------------------------------
function [LW-1:0] burst_len;
    input [`SDCI_OPC_W-1:0] mode;
    begin
        if (mode[`SDCI_MR_BL_MSB:`SDCI_MR_BL_LSB] == `SDCI_BL_PAGE) begin
            burst_len = {1'b1, {COL_W{1'b0}}};
        end else begin
            burst_len = {{(LW-1){1'b0}}, 1'b1} <<
                mode[`SDCI_MR_BL_LSB+1:`SDCI_MR_BL_LSB];
        end
    end
endfunction

function [COL_W-1:0] burst_col;
    input [COL_W-1:0] start;
    input [LW-1:0] cnt;
    input [LW-1:0] len;
    input il;
    reg [LW-1:0] lmask;
    reg [COL_W-1:0] mask;
    reg [COL_W-1:0] offs;
    begin
        lmask = len - {{(LW-1){1'b0}}, 1'b1};
        mask = lmask[COL_W-1:0];
        if (il) begin
            offs = (start & mask) ^ cnt[COL_W-1:0];
        end else begin
            offs = ((start & mask) + cnt[COL_W-1:0]) & mask;
        end
        burst_col = (start & ~mask) | offs;
    end
endfunction

// ----------------------------------------------------------------
// Input capture
// ----------------------------------------------------------------
reg [3:0] cmd;
reg cke;
reg [BANK_W-1:0] ba;
reg [`SDCI_OPC_W-1:0] addr;
reg [LANES-1:0] dqm;
reg [LANES-1:0] dqm_d1;
reg [DATA_W-1:0] dq;

always @(posedge sys_clk_in) begin
    if (srst_in) begin
        cmd <= `SDCI_CMD_NOP;
        cke <= 1'b0;
        ba <= {BANK_W{1'b0}};
        addr <= {`SDCI_OPC_W{1'b0}};
        dqm <= `SDCI_LANE_ON;
        dqm_d1 <= `SDCI_LANE_ON;
        dq <= {DATA_W{1'b0}};
    end else begin
        // Inhibit folds into NOP
        cmd <= cs_n_in ? `SDCI_CMD_NOP :
            {1'b0, ras_n_in, cas_n_in, we_n_in};
        cke <= cke_in;
        ba <= ba_in;
        addr <= addr_in;
        dqm <= dqm_in;
        dqm_d1 <= dqm;
        dq <= dq_in;
    end
end

// ----------------------------------------------------------------
// Command decode
// ----------------------------------------------------------------
reg self_ref;
wire live = cke && !self_ref;
wire is_act = live && cmd == `SDCI_CMD_ACT;
wire is_rd = live && cmd == `SDCI_CMD_RD;
wire is_wr = live && cmd == `SDCI_CMD_WR;
wire is_bst = live && cmd == `SDCI_CMD_BST;
wire is_pre = live && cmd == `SDCI_CMD_PRE;
wire is_lmr = live && cmd == `SDCI_CMD_LMR;
wire is_aref = live && cmd == `SDCI_CMD_REF;
wire is_sref = !cke && !self_ref && cmd == `SDCI_CMD_REF;
wire pre_all = addr[`SDCI_AP_BIT];

// ----------------------------------------------------------------
// Bank and mode state
// ----------------------------------------------------------------
reg [`SDCI_OPC_W-1:0] mode;
reg [ROW_W-1:0] open_row [0:NB-1];
reg [DATA_W-1:0] mem [0:(1<<AW)-1];

// ----------------------------------------------------------------
// Burst engine
// ----------------------------------------------------------------
reg bur_act;
reg bur_wr;
reg bur_il;
reg bur_ap;
reg [BANK_W-1:0] bur_bank;
reg [COL_W-1:0] bur_start;
reg [LW-1:0] bur_cnt;
reg [LW-1:0] bur_len;

reg acc_go;
reg acc_wr;
reg acc_il;
reg acc_ap;
reg [BANK_W-1:0] acc_bank;
reg [COL_W-1:0] acc_start;
reg [LW-1:0] acc_cnt;
reg [LW-1:0] acc_len;
reg [COL_W-1:0] acc_col;
reg acc_last;
reg [AW-1:0] acc_addr;

wire pre_hit = is_pre && (pre_all || ba == bur_bank);

always @* begin
    acc_go = 1'b0;
    acc_wr = bur_wr;
    acc_il = bur_il;
    acc_ap = bur_ap;
    acc_bank = bur_bank;
    acc_start = bur_start;
    acc_cnt = bur_cnt;
    acc_len = bur_len;
    if (is_rd || is_wr) begin
        // New access truncates any running burst
        acc_go = 1'b1;
        acc_wr = is_wr;
        acc_il = mode[`SDCI_MR_BT_BIT];
        acc_ap = addr[`SDCI_AP_BIT];
        acc_bank = ba;
        acc_start = addr[COL_W-1:0];
        acc_cnt = {LW{1'b0}};
        if (is_wr && mode[`SDCI_MR_WB_BIT]) begin
            acc_len = {{(LW-1){1'b0}}, 1'b1};
        end else begin
            acc_len = burst_len(mode);
        end
    end else if (bur_act && cke && !is_bst && !pre_hit) begin
        acc_go = 1'b1;
    end
    acc_col = burst_col(acc_start, acc_cnt, acc_len, acc_il);
    acc_last = (acc_cnt + {{(LW-1){1'b0}}, 1'b1}) == acc_len;
    acc_addr = {acc_bank, open_row[acc_bank], acc_col};
end

// ----------------------------------------------------------------
// Read pipeline
// ----------------------------------------------------------------
wire [2:0] cas_lat = mode[`SDCI_MR_CL_MSB:`SDCI_MR_CL_LSB];
wire rd_push = acc_go && !acc_wr;
wire [DATA_W-1:0] rd_word = mem[acc_addr];
reg [DATA_W-1:0] pipe1;
reg [DATA_W-1:0] pipe2;
reg pv1;
reg pv2;
reg next_valid;

always @* begin
    next_valid = pv1;
    if (rd_push && cas_lat == `SDCI_CL_ONE) begin
        next_valid = 1'b1;
    end
end

// ----------------------------------------------------------------
// Main sequencer
// ----------------------------------------------------------------
integer i;

always @(posedge sys_clk_in) begin
    if (srst_in) begin
        mode <= `SDCI_MODE_RST;
        self_ref <= 1'b0;
        bank_open_out <= {NB{1'b0}};
        self_refresh_out <= 1'b0;
        refresh_row_out <= {ROW_W{1'b0}};
        bur_act <= 1'b0;
        bur_wr <= 1'b0;
        bur_il <= 1'b0;
        bur_ap <= 1'b0;
        bur_bank <= {BANK_W{1'b0}};
        bur_start <= {COL_W{1'b0}};
        bur_cnt <= {LW{1'b0}};
        bur_len <= {LW{1'b0}};
        pipe1 <= {DATA_W{1'b0}};
        pipe2 <= {DATA_W{1'b0}};
        pv1 <= 1'b0;
        pv2 <= 1'b0;
        dq_out <= {DATA_W{1'b0}};
        dq_oe_out <= {LANES{1'b0}};
        for (i = 0; i < NB; i = i + 1) begin
            open_row[i] <= {ROW_W{1'b0}};
        end
    end else begin
        // Mode load
        if (is_lmr) begin
            mode <= addr;
        end
        // Row open and close
        if (is_act) begin
            bank_open_out[ba] <= 1'b1;
            open_row[ba] <= addr[ROW_W-1:0];
        end
        if (is_pre) begin
            if (pre_all) begin
                bank_open_out <= {NB{1'b0}};
            end else begin
                bank_open_out[ba] <= 1'b0;
            end
        end
        // Refresh
        if (is_aref || is_sref) begin
            refresh_row_out <= refresh_row_out + {{(ROW_W-1){1'b0}}, 1'b1};
        end
        if (is_sref) begin
            self_ref <= 1'b1;
            self_refresh_out <= 1'b1;
        end else if (self_ref && cke) begin
            self_ref <= 1'b0;
            self_refresh_out <= 1'b0;
        end
        // Burst progress
        if (acc_go) begin
            bur_act <= !acc_last;
            bur_wr <= acc_wr;
            bur_il <= acc_il;
            bur_ap <= acc_ap;
            bur_bank <= acc_bank;
            bur_start <= acc_start;
            bur_len <= acc_len;
            bur_cnt <= acc_cnt + {{(LW-1){1'b0}}, 1'b1};
            if (acc_last && acc_ap) begin
                bank_open_out[acc_bank] <= 1'b0;
            end
            if (acc_wr) begin
                for (i = 0; i < LANES; i = i + 1) begin
                    if (!dqm[i]) begin
                        mem[acc_addr][i*BW +: BW] <= dq[i*BW +: BW];
                    end
                end
            end
        end else if (is_bst || pre_hit) begin
            bur_act <= 1'b0;
        end
        // Read data staged by latency
        pipe1 <= pipe2;
        pv1 <= pv2;
        pv2 <= 1'b0;
        dq_out <= pipe1;
        if (rd_push) begin
            case (cas_lat)
                `SDCI_CL_ONE: begin
                    dq_out <= rd_word;
                end
                `SDCI_CL_TWO: begin
                    pipe1 <= rd_word;
                    pv1 <= 1'b1;
                end
                default: begin
                    pipe2 <= rd_word;
                    pv2 <= 1'b1;
                end
            endcase
        end
        dq_oe_out <= {LANES{next_valid}} & ~dqm_d1;
    end
end

endmodule // sdci_core

//--- sdci_core_props.sv
`timescale 1ns/1ns
`include "sdci_regs.vh"
// --------------------
// Port checker
// --------------------
module sdci_core_props #(
    parameter BANK_W = 2,
    parameter ROW_W = 11,
    parameter LANES = 4
)(
    // Clock and reset
    input wire sys_clk_in,
    input wire srst_in,
    // Command pins
    input wire cs_n_in,
    input wire ras_n_in,
    input wire cas_n_in,
    input wire we_n_in,
    input wire cke_in,
    input wire [BANK_W-1:0] ba_in,
    input wire [`SDCI_OPC_W-1:0] addr_in,
    input wire [LANES-1:0] dqm_in,
    // Outputs
    input wire [LANES-1:0] dq_oe_out,
    input wire [(1<<BANK_W)-1:0] bank_open_out,
    input wire self_refresh_out,
    input wire [ROW_W-1:0] refresh_row_out
);
    wire [3:0] cmd = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
    wire go = cke_in && !self_refresh_out;
    default clocking dc @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    a_act_opens: assert property (cmd == `SDCI_CMD_ACT && go
        |-> ##2 bank_open_out[$past(ba_in, 2)]) else $error("no open");
    a_only_act: assert property (!(cmd == `SDCI_CMD_ACT && go)
        |-> ##2 !(bank_open_out & ~$past(bank_open_out)))
        else $error("stray open");
    a_pre_all: assert property (cmd == `SDCI_CMD_PRE && go
        && addr_in[`SDCI_AP_BIT] |-> ##2 bank_open_out == 0)
        else $error("pre all");
    a_pre_one: assert property (cmd == `SDCI_CMD_PRE && go
        && !addr_in[`SDCI_AP_BIT] |-> ##2 !bank_open_out[$past(ba_in, 2)])
        else $error("pre one");
    a_self_in: assert property (cmd == `SDCI_CMD_REF && !cke_in
        && !self_refresh_out |-> ##2 self_refresh_out) else $error("self");
    a_self_out: assert property (self_refresh_out && cke_in
        |-> ##2 !self_refresh_out) else $error("no exit");
    a_ref_count: assert property (cmd == `SDCI_CMD_REF && go
        |-> ##2 refresh_row_out == $past(refresh_row_out) + 1'b1)
        else $error("ref row");
    a_oe_mask: assert property (
        (dq_oe_out & $past(dqm_in, 3)) == 0) else $error("oe mask");
endmodule // sdci_core_props

bind sdci_core sdci_core_props #(.BANK_W(BANK_W), .ROW_W(ROW_W),
    .LANES(LANES)) u_props (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
    .cs_n_in(cs_n_in), .ras_n_in(ras_n_in), .cas_n_in(cas_n_in),
    .we_n_in(we_n_in), .cke_in(cke_in), .ba_in(ba_in), .addr_in(addr_in),
    .dqm_in(dqm_in), .dq_oe_out(dq_oe_out), .bank_open_out(bank_open_out),
    .self_refresh_out(self_refresh_out), .refresh_row_out(refresh_row_out));

//--- sdci_ctrl.sv
`timescale 1ns/1ns
`include "sdci_regs.vh"
// --------------------
// Command bus driver
// --------------------
module sdci_ctrl (
    // Clock
    input wire sys_clk_in,
    // Command pins
    output logic [3:0] cmd_out,
    output logic cke_out,
    // Address and data
    output logic [1:0] ba_out,
    output logic [11:0] addr_out,
    output logic [3:0] dqm_out,
    output logic [31:0] dq_out
);
    initial begin
        cmd_out = `SDCI_CMD_NOP;
        cke_out = 1'b0;
        ba_out = 2'h0;
        addr_out = 12'h000;
        dqm_out = 4'hf;
        dq_out = 32'h0;
    end
    task issue(input logic [3:0] c, input logic k, input logic [1:0] b,
            input logic [11:0] a, input logic [31:0] d, input logic [3:0] m);
        cmd_out = c;
        cke_out = k;
        ba_out = b;
        addr_out = a;
        dq_out = d;
        dqm_out = m;
        @(negedge sys_clk_in);
    endtask
    task idle;
        cmd_out = `SDCI_CMD_NOP;
        ba_out = ~ba_out;
        addr_out = ~addr_out;
        dq_out = ~dq_out;
    endtask
endmodule // sdci_ctrl

//--- sdci_regs.vh
`ifndef SDCI_REGS_VH
`define SDCI_REGS_VH

// ----------------------------------------------------------------
// Command codes as {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------------------------------
`define SDCI_CMD_LMR 4'h0
`define SDCI_CMD_REF 4'h1
`define SDCI_CMD_PRE 4'h2
`define SDCI_CMD_ACT 4'h3
`define SDCI_CMD_WR 4'h4
`define SDCI_CMD_RD 4'h5
`define SDCI_CMD_BST 4'h6
`define SDCI_CMD_NOP 4'h7

// ----------------------------------------------------------------
// Address fields
// ----------------------------------------------------------------
`define SDCI_AP_BIT 10
`define SDCI_OPC_W 12

// ----------------------------------------------------------------
// Mode word fields
// ----------------------------------------------------------------
`define SDCI_MR_BL_MSB 2
`define SDCI_MR_BL_LSB 0
`define SDCI_MR_BT_BIT 3
`define SDCI_MR_CL_MSB 6
`define SDCI_MR_CL_LSB 4
`define SDCI_MR_WB_BIT 9
`define SDCI_BL_PAGE 3'h7
`define SDCI_CL_ONE 3'h1
`define SDCI_CL_TWO 3'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SDCI_MODE_RST 12'h020
`define SDCI_LANE_ON 4'hf

`endif

//--- tb_sdram_command_interface.sv
`timescale 1ns/1ns
`include "sdci_regs.vh"
module tb_sdram_command_interface;
    logic sys_clk_in, srst_in, cke, self_ref;
    logic [3:0] cmd, dqm, oe, open_b, exp_open, wm, rm, sm;
    logic [1:0] ba;
    logic [11:0] addr;
    logic [31:0] dq_w, dq_r, d, lm;
    logic [10:0] ref_row;
    logic [31:0] mem [int];
    int err_count, checks, seed, i, cl, b, r, c, ap, key;
    sdci_ctrl ctrl (.sys_clk_in(sys_clk_in), .cmd_out(cmd), .cke_out(cke),
        .ba_out(ba), .addr_out(addr), .dqm_out(dqm), .dq_out(dq_w));
    sdci_core dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
        .cs_n_in(cmd[3]), .ras_n_in(cmd[2]), .cas_n_in(cmd[1]),
        .we_n_in(cmd[0]), .cke_in(cke), .ba_in(ba), .addr_in(addr),
        .dqm_in(dqm), .dq_in(dq_w), .dq_out(dq_r), .dq_oe_out(oe),
        .bank_open_out(open_b), .self_refresh_out(self_ref),
        .refresh_row_out(ref_row));
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task test_done;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task op(input logic [3:0] x, input logic k, input logic [1:0] y,
            input logic [11:0] a);
        ctrl.issue(x, k, y, a, 32'h0, 4'hf);
        ctrl.idle;
        @(negedge sys_clk_in);
    endtask
    initial begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    // Run needs about 210 cycles
    initial begin
        #80000;
        err_count++;
        test_done;
    end
    initial begin
        srst_in = 1'b1;
        seed = 57;
        exp_open = 4'h0;
        repeat (12) @(negedge sys_clk_in);
        srst_in = 1'b0;
        chk("rst", {open_b, self_ref, ref_row, oe}, 0);
        op(`SDCI_CMD_REF, 1, 0, 0);
        op(`SDCI_CMD_REF, 1, 0, 0);
        chk("aref", ref_row, 2);
        for (cl = 2; cl > 0; cl--) begin
            if (cl == 1) begin
                op(`SDCI_CMD_LMR, 1, 0, 12'h010);
            end
            for (i = 0; i < 8; i++) begin
                b = $random(seed) & 3;
                r = $random(seed) & 12'h7ff;
                c = $random(seed) & 8'hff;
                d = $random(seed);
                wm = $random(seed);
                rm = $random(seed);
                ap = $random(seed) & 1;
                op(i[0] ? 4'hb : `SDCI_CMD_NOP, 1, b, r);
                chk("inh", open_b, exp_open);
                op(`SDCI_CMD_ACT, 1, b, r);
                exp_open[b] = 1'b1;
                chk("act", open_b, exp_open);
                key = (b << 19) | (r << 8) | c;
                mem[key] = d;
                sm = (cl == 2) ? rm : wm;
                lm = {{8{!wm[3]}}, {8{!wm[2]}}, {8{!wm[1]}}, {8{!wm[0]}}};
                lm = lm & {{8{!sm[3]}}, {8{!sm[2]}}, {8{!sm[1]}}, {8{!sm[0]}}};
                ctrl.issue(`SDCI_CMD_WR, 1, b, c, d, wm);
                ctrl.issue(`SDCI_CMD_RD, 1, b, c | (ap << 10), 0, rm);
                ctrl.idle;
                repeat (cl) @(negedge sys_clk_in);
                chk("oe", oe, {28'h0, ~sm});
                chk("rd", dq_r & lm, mem[key] & lm);
                @(negedge sys_clk_in);
                if (!ap) begin
                    op(`SDCI_CMD_PRE, 1, b, 0);
                end
                exp_open[b] = 1'b0;
                chk("close", open_b, exp_open);
            end
        end
        // Burst of four, interleaved, latency three
        op(`SDCI_CMD_LMR, 1, 0, 12'h03a);
        r = $random(seed) & 12'h7ff;
        c = $random(seed) & 8'hff;
        op(`SDCI_CMD_ACT, 1, 1, r);
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            key = (1 << 19) | (r << 8) | (c & 8'hfc) | ((c & 3) ^ i);
            mem[key] = d;
            ctrl.issue((i == 0) ? `SDCI_CMD_WR : `SDCI_CMD_NOP,
                1, 1, c, d, 0);
        end
        c = c ^ 1;
        ctrl.issue(`SDCI_CMD_RD, 1, 1, c, 0, 0);
        ctrl.idle;
        repeat (3) @(negedge sys_clk_in);
        for (i = 0; i < 4; i++) begin
            key = (1 << 19) | (r << 8) | (c & 8'hfc) | ((c & 3) ^ i);
            chk("burst", dq_r, mem[key]);
            chk("boe", oe, 4'hf);
            @(negedge sys_clk_in);
        end
        ctrl.issue(`SDCI_CMD_RD, 1, 1, c, 0, 0);
        ctrl.issue(`SDCI_CMD_BST, 1, 1, 0, 0, 0);
        ctrl.idle;
        repeat (2) @(negedge sys_clk_in);
        chk("bst0", dq_r, mem[(1 << 19) | (r << 8) | c]);
        @(negedge sys_clk_in);
        chk("bst1", oe, 0);
        op(`SDCI_CMD_PRE, 1, 0, 12'h400);
        chk("pre4", open_b, 0);
        ctrl.issue(`SDCI_CMD_ACT, 1, 0, 5, 0, 4'hf);
        op(`SDCI_CMD_ACT, 1, 3, 9);
        chk("act2", open_b, 4'h9);
        op(`SDCI_CMD_PRE, 1, 1, 12'h400);
        chk("preall", open_b, 0);
        op(`SDCI_CMD_REF, 0, 0, 0);
        chk("self", {self_ref, ref_row}, {1'b1, 11'h3});
        op(`SDCI_CMD_ACT, 0, 2, 7);
        chk("sleep", open_b, 0);
        op(`SDCI_CMD_NOP, 1, 0, 0);
        repeat (2) @(negedge sys_clk_in);
        chk("wake", self_ref, 0);
        op(`SDCI_CMD_REF, 1, 0, 0);
        op(`SDCI_CMD_REF, 1, 0, 0);
        chk("reref", ref_row, 5);
        test_done;
    end
endmodule // tb_sdram_command_interface
